// >>> rtl/ldc_lcd_ctrl.sv
// LCD drive control: AHB-Lite registers, frame clock, charge pulse, commons.
// Assumes one hclk domain; sub_clk_in is an unsynchronised subclock pin.
// Summary of operation
// - Duty field picks static, half, third or quarter duty and commons
// - Static with expansion: commons two to four copy common one
// - Half with expansion: four copies three, two copies one
// - Third with expansion: common four drives non-selected level
// - Run bit low halts the driver; high runs and makes waveforms
// - Drive-supply bit switches the LCD drive supply off or on
// - Charge field sets pulse duty: 1, k/8, 0, 1/16 or 1/32
// - Regulator bit halts or runs the 5 V regulator
// - Waveform bit picks A or B drive waveform
`include "ldc_consts.svh"
module ldc_lcd_ctrl
    import ldc_pkg::*;
(
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    input  wire logic        sub_clk_in,
    output ldc_level_t       common_out_one,
    output ldc_level_t       common_out_two,
    output ldc_level_t       common_out_three,
    output ldc_level_t       common_out_four,
    output logic             drive_supply_on,
    output logic             regulator_on,
    output logic             show_ram_contents,
    output logic             charge_pulse
);
    // Word address compare, shared by write and read decode
    function automatic logic is_reg(input logic [31:0] a,
                                    input logic [7:0]  idx);
        return a == {22'h0, idx, 2'b00};
    endfunction

    // Charge pulse high steps out of a 32-step period
    function automatic logic [5:0] chg_thr(input logic [3:0] c);
        logic [5:0] t;
        t = 6'h00;
        if (c[3]) begin
            t = c[2] ? 6'h01 : 6'h02;
        end else if (c[2:0] == 3'h0) begin
            t = `LDC_CHG_STEPS;
        end else if (c[2:0] != 3'h7) begin
            t = {1'b0, c[2:0], 2'b00};
        end
        return t;
    endfunction

    logic        addr_ph;
    logic        wr_pend_ff;
    logic [31:0] wr_addr_ff;
    logic [7:0]  duty_ff, nxt_duty_ff;
    logic [6:0]  ctrl_ff, nxt_ctrl_ff;
    logic [5:0]  drv_ff,  nxt_drv_ff;
    logic [31:0] hrdata_ff;
    logic [7:0]  rd_mux;
    logic [1:0]  slot;
    logic        polarity;
    logic        run;
    logic [3:0]  cks;

    assign addr_ph   = hsel & htrans[1] & hready;
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;

    // Capture a word write address phase for the following data phase
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_ff <= 1'b0;
            wr_addr_ff <= 32'h0000_0000;
        end else begin
            wr_pend_ff <= addr_ph & hwrite & (hsize == 3'h2);
            wr_addr_ff <= haddr;
        end
    end

    // Next register values; reads forward these so back-to-back is exact
    always_comb begin
        nxt_duty_ff = duty_ff;
        nxt_ctrl_ff = ctrl_ff;
        nxt_drv_ff  = drv_ff;
        if (wr_pend_ff && is_reg(wr_addr_ff, `LDC_DUTY_IDX)) begin
            nxt_duty_ff = hwdata[7:0];
        end
        if (wr_pend_ff && is_reg(wr_addr_ff, `LDC_CTRL_IDX)) begin
            nxt_ctrl_ff = hwdata[6:0];
        end
        if (wr_pend_ff && is_reg(wr_addr_ff, `LDC_DRV_IDX)) begin
            nxt_drv_ff = {hwdata[`LDC_WAVE_BIT], hwdata[`LDC_REG_BIT],
                          hwdata[`LDC_CDS_HI:0]};
        end
    end

    // Register storage
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            duty_ff <= `LDC_DUTY_RST;
            ctrl_ff <= `LDC_CTRL_RST;
            drv_ff  <= `LDC_DRV_RST;
        end else begin
            duty_ff <= nxt_duty_ff;
            ctrl_ff <= nxt_ctrl_ff;
            drv_ff  <= nxt_drv_ff;
        end
    end

    // Read decode; reserved bits of control and drive read one, unmapped reads zero
    always_comb begin
        rd_mux = 8'h00;
        if (is_reg(haddr, `LDC_DUTY_IDX)) begin
            rd_mux = nxt_duty_ff;
        end else if (is_reg(haddr, `LDC_CTRL_IDX)) begin
            rd_mux = `LDC_CTRL_ONES | {1'b0, nxt_ctrl_ff};
        end else if (is_reg(haddr, `LDC_DRV_IDX)) begin
            rd_mux = `LDC_DRV_ONES | {nxt_drv_ff[5], 2'b00,
                                      nxt_drv_ff[4:0]};
        end else if (is_reg(haddr, `LDC_STAT_IDX)) begin
            rd_mux = {4'h0, run, polarity, slot};
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata_ff <= 32'h0000_0000;
        end else if (addr_ph && !hwrite) begin
            hrdata_ff <= {24'h00_0000, rd_mux};
        end
    end
    assign hrdata = hrdata_ff;

    assign run = ctrl_ff[`LDC_RUN_BIT];
    assign cks = ctrl_ff[`LDC_CKS_HI:0];

    // Subclock pin: two-stage sync, third stage only for edge detect
    logic sub_s1_ff, sub_s2_ff, sub_s3_ff, sub_half_ff;
    logic [7:0] sys_div_ff;
    logic       frame_tick_ff;
    logic       sub_rise;
    logic [7:0] div_mask;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sub_s1_ff   <= 1'b0;
            sub_s2_ff   <= 1'b0;
            sub_s3_ff   <= 1'b0;
            sub_half_ff <= 1'b0;
        end else begin
            sub_s1_ff <= sub_clk_in;
            sub_s2_ff <= sub_s1_ff;
            sub_s3_ff <= sub_s2_ff;
            if (sub_rise) begin
                sub_half_ff <= ~sub_half_ff;
            end
        end
    end
    assign sub_rise = sub_s2_ff & ~sub_s3_ff;
    assign div_mask = 8'((9'h002 << cks[2:0]) - 9'h001);

    // Frame tick selection; system divider runs free so ticks stay regular
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sys_div_ff    <= 8'h00;
            frame_tick_ff <= 1'b0;
        end else begin
            sys_div_ff <= sys_div_ff + 8'h01;
            if (cks[3]) begin
                frame_tick_ff <= (sys_div_ff & div_mask) == div_mask;
            end else if (cks[1]) begin
                frame_tick_ff <= sub_rise & sub_half_ff;
            end else begin
                frame_tick_ff <= sub_rise;
            end
        end
    end

    ldc_com_gen u_com (
        .hclk             (hclk),
        .hresetn          (hresetn),
        .frame_tick       (frame_tick_ff),
        .run              (run),
        .duty             (ldc_duty_t'(duty_ff[`LDC_DUTY_HI:`LDC_DUTY_LO])),
        .common_expansion              (duty_ff[`LDC_CMX_BIT]),
        .wave_b           (drv_ff[5]),
        .common_out_one   (common_out_one),
        .common_out_two   (common_out_two),
        .common_out_three (common_out_three),
        .common_out_four  (common_out_four),
        .slot             (slot),
        .polarity         (polarity)
    );

    // Charge pulse PWM over 32 hclk steps; thresholds come from the field
    logic [4:0] chg_ph_ff;
    logic       chg_ff;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            chg_ph_ff <= 5'h00;
            chg_ff    <= 1'b0;
        end else begin
            chg_ph_ff <= chg_ph_ff + 5'h01;
            chg_ff    <= {1'b0, chg_ph_ff} < chg_thr(drv_ff[3:0]);
        end
    end
    assign charge_pulse = chg_ff;

    // Plain level controls straight from registers
    assign drive_supply_on   = ctrl_ff[`LDC_SUPPLY_BIT];
    assign show_ram_contents = ctrl_ff[`LDC_SHOW_BIT];
    assign regulator_on      = drv_ff[4];

    // Register effects seen one edge after the write lands
    supply_write_a: assert property (
        @(posedge hclk) disable iff (!hresetn)
        wr_pend_ff && is_reg(wr_addr_ff, `LDC_CTRL_IDX) |=>
            drive_supply_on == $past(hwdata[`LDC_SUPPLY_BIT]))
        else $error("drive supply level differs from written bit");
    regulator_write_a: assert property (
        @(posedge hclk) disable iff (!hresetn)
        wr_pend_ff && is_reg(wr_addr_ff, `LDC_DRV_IDX) |=>
            regulator_on == $past(hwdata[`LDC_REG_BIT]))
        else $error("regulator level differs from written bit");
    // End codes of the charge field; reset edge excluded on purpose
    chg_full_a: assert property (
        @(posedge hclk) disable iff (!hresetn)
        $past(hresetn && drv_ff[3:0] == 4'h0) |-> charge_pulse)
        else $error("charge pulse low with full duty code");
    chg_zero_a: assert property (
        @(posedge hclk) disable iff (!hresetn)
        $past(drv_ff[3:0] == 4'h7) |-> !charge_pulse)
        else $error("charge pulse high with zero duty code");
endmodule

// >>> rtl/ldc_consts.svh
// Register map, field positions and reset values of the LCD drive control.
// Assumes a 32-bit AHB-Lite slave with one register per aligned word.
`ifndef LDC_CONSTS_SVH
`define LDC_CONSTS_SVH

// Register indices; byte address is four times the index
`define LDC_DUTY_IDX    8'hC0
`define LDC_CTRL_IDX    8'hC1
`define LDC_DRV_IDX     8'hC2
`define LDC_STAT_IDX    8'hC3

// Duty / common register fields
`define LDC_DUTY_HI     7
`define LDC_DUTY_LO     6
`define LDC_CMX_BIT     5
`define LDC_DUTY_RST    8'h00

// Control register fields
`define LDC_SUPPLY_BIT  6
`define LDC_RUN_BIT     5
`define LDC_SHOW_BIT    4
`define LDC_CKS_HI      3
`define LDC_CTRL_RST    7'h00
`define LDC_CTRL_ONES   8'h80

// Drive control register fields
`define LDC_WAVE_BIT    7
`define LDC_REG_BIT     4
`define LDC_CDS_HI      3
`define LDC_DRV_RST     6'h00
`define LDC_DRV_ONES    8'h60

// Charge pulse period in system clocks
`define LDC_CHG_STEPS   6'h20

`endif

// >>> rtl/ldc_pkg.sv
// Types shared by the LCD drive control modules.
// Assumes nothing beyond a SystemVerilog compiler.
package ldc_pkg;
    // Drive level of one common electrode
    typedef enum logic [1:0] {
        LDC_GND,
        LDC_NONSEL,
        LDC_SEL_HI,
        LDC_SEL_LO
    } ldc_level_t;

    // Multiplex duty codes
    typedef enum logic [1:0] {
        LDC_STATIC,
        LDC_HALF,
        LDC_THIRD,
        LDC_QUARTER
    } ldc_duty_t;
endpackage

// >>> rtl/ldc_com_gen.sv
// Common electrode waveform generator: slot sequencing and polarity.
// Assumes frame_tick is a one-cycle enable on hclk and settings are static.
module ldc_com_gen
    import ldc_pkg::*;
(
    input  wire logic       hclk,
    input  wire logic       hresetn,
    input  wire logic       frame_tick,
    input  wire logic       run,
    input  wire ldc_duty_t  duty,
    input  wire logic       common_expansion,
    input  wire logic       wave_b,
    output ldc_level_t      common_out_one,
    output ldc_level_t      common_out_two,
    output ldc_level_t      common_out_three,
    output ldc_level_t      common_out_four,
    output logic [1:0]      slot,
    output logic            polarity
);
    logic [1:0] slot_ff;
    logic       pol_ff;
    ldc_level_t lvl_ff [4];
    logic       last_slot;

    assign last_slot = (slot_ff >= 2'(duty));

    // Slot counter walks the active commons, halted state parks at zero
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            slot_ff <= 2'h0;
        end else if (!run) begin
            slot_ff <= 2'h0;
        end else if (frame_tick) begin
            slot_ff <= last_slot ? 2'h0 : slot_ff + 2'h1;
        end
    end

    // A flips every slot, B only at frame end to keep DC off the panel
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pol_ff <= 1'b0;
        end else if (!run) begin
            pol_ff <= 1'b0;
        end else if (frame_tick && (!wave_b || last_slot)) begin
            pol_ff <= ~pol_ff;
        end
    end

    // One level register per common; mapping follows duty and expansion
    for (genvar i = 0; i < 4; i++) begin : g_com
        logic       en;
        logic [1:0] src;
        logic       force_ns;
        always_comb begin
            en       = 1'b1;
            src      = 2'(i);
            force_ns = 1'b0;
            unique case (duty)
                LDC_STATIC: begin
                    en  = (i == 0) || common_expansion;
                    src = 2'h0;
                end
                LDC_HALF: begin
                    en  = (i < 2) || common_expansion;
                    src = common_expansion ? 2'(i / 2) : 2'(i);
                end
                LDC_THIRD: begin
                    en       = (i < 3) || common_expansion;
                    force_ns = (i == 3);
                end
                LDC_QUARTER: begin
                    en = 1'b1;
                end
            endcase
        end
        always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
                lvl_ff[i] <= LDC_GND;
            end else if (!run || !en) begin
                lvl_ff[i] <= LDC_GND;
            end else if (!force_ns && src == slot_ff) begin
                lvl_ff[i] <= pol_ff ? LDC_SEL_HI : LDC_SEL_LO;
            end else begin
                lvl_ff[i] <= LDC_NONSEL;
            end
        end
    end

    // Mapping checks; levels follow the settings one edge later
    unused_gnd_a: assert property (
        @(posedge hclk) disable iff (!hresetn)
        $past(!common_expansion && duty != LDC_QUARTER) |-> lvl_ff[3] == LDC_GND)
        else $error("common four driven while unused");
    static_copy_a: assert property (
        @(posedge hclk) disable iff (!hresetn)
        $past(duty == LDC_STATIC && common_expansion) |->
            (lvl_ff[1] == lvl_ff[0] && lvl_ff[2] == lvl_ff[0] &&
             lvl_ff[3] == lvl_ff[0]))
        else $error("static expansion commons differ");
    half_copy_a: assert property (
        @(posedge hclk) disable iff (!hresetn)
        $past(duty == LDC_HALF && common_expansion) |->
            (lvl_ff[3] == lvl_ff[2] && lvl_ff[1] == lvl_ff[0]))
        else $error("half expansion commons differ");
    third_nonsel_a: assert property (
        @(posedge hclk) disable iff (!hresetn)
        $past(duty == LDC_THIRD && common_expansion && run) |->
            lvl_ff[3] == LDC_NONSEL)
        else $error("common four not at non-selected level");
    halt_gnd_a: assert property (
        @(posedge hclk) disable iff (!hresetn)
        $past(!run) |->
            (lvl_ff[0] == LDC_GND && lvl_ff[1] == LDC_GND &&
             lvl_ff[2] == LDC_GND && lvl_ff[3] == LDC_GND))
        else $error("commons driven while halted");
    // B keeps polarity inside a frame, so only the frame end flips it
    wave_b_hold_a: assert property (
        @(posedge hclk) disable iff (!hresetn)
        frame_tick && wave_b && run && !last_slot |=> $stable(pol_ff))
        else $error("polarity flipped inside a frame");

    assign common_out_one   = lvl_ff[0];
    assign common_out_two   = lvl_ff[1];
    assign common_out_three = lvl_ff[2];
    assign common_out_four  = lvl_ff[3];
    assign slot             = slot_ff;
    assign polarity         = pol_ff;
endmodule

// >>> dv/ldc_panel_model.sv
// Panel model on the four common electrodes.
// Assumes commons are registered levels on hclk.
module ldc_panel_model
    import ldc_pkg::*;
(
    input  wire logic        hclk,
    input  ldc_level_t       com [4],
    output logic      [15:0] sel_cnt [4]
);
    timeunit 1ns;
    timeprecision 1ns;
    // Panel sees a segment lit only on a selected common level
    always @(posedge hclk) begin
        for (int i = 0; i < 4; i++) begin
            if (sel_cnt[i] === 16'hXXXX)
                sel_cnt[i] = 16'h0000;
            if (com[i] == LDC_SEL_HI || com[i] == LDC_SEL_LO)
                sel_cnt[i] = sel_cnt[i] + 16'h0001;
        end
    end
endmodule

// >>> dv/lcd_drive_control_test.sv
// Self-checking bench for the LCD drive control block.
// Assumes this bench is the only AHB-Lite master and a panel on commons.
module lcd_drive_control_test
    import ldc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic        hclk = 0, hresetn = 0, hwrite = 0, sub_clk = 0;
    logic [1:0]  htrans = 2'h0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
    logic        hreadyout, hresp, sup, reg_on, show, chg;
    ldc_level_t  com [4];
    logic [15:0] sel_cnt [4];
    logic [15:0] c0;
    int          n_mismatch = 0, cmp_count = 0, k;
    // Rows: address, write data, {supply, regulator, show}; read back values sit in rdx
    logic [22:0] row [7] = '{
        {12'h304, 8'h40, 3'b100}, {12'h304, 8'h10, 3'b001},
        {12'h308, 8'h10, 3'b011}, {12'h308, 8'h8F, 3'b001},
        {12'h300, 8'hE0, 3'b001}, {12'h310, 8'hFF, 3'b001},
        {12'h304, 8'h00, 3'b000}};
    logic [7:0]  rdx [7] = '{8'hC0, 8'h90, 8'h70, 8'hEF, 8'hE0,
                             8'h00, 8'h80};
    logic [3:0]  cds [6] = '{4'h0, 4'h1, 4'h6, 4'h7, 4'h8, 4'hC};
    int          hi_x [6] = '{32, 4, 24, 0, 2, 1};
    logic [7:0]  duty [5] = '{8'h20, 8'h60, 8'hA0, 8'h80, 8'h00};
    // Frame clock rows: code, window in cycles, ticks in that window
    logic [3:0]  cks_v [5] = '{4'h0, 4'h1, 4'h2, 4'hB, 4'hF};
    int          cks_w [5] = '{224, 224, 224, 224, 512};
    int          cks_n [5] = '{16, 16, 8, 14, 2};
    ldc_level_t  lv;

    always #50 hclk = ~hclk;
    // Subclock period of exactly 14 hclk cycles keeps tick counts exact
    always #700 sub_clk = ~sub_clk;

    ldc_lcd_ctrl DUT (.hclk(hclk), .hresetn(hresetn), .hsel(1'b1),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
        .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .sub_clk_in(sub_clk),
        .common_out_one(com[0]), .common_out_two(com[1]),
        .common_out_three(com[2]), .common_out_four(com[3]),
        .drive_supply_on(sup), .regulator_on(reg_on),
        .show_ram_contents(show), .charge_pulse(chg));
    ldc_panel_model panel (.hclk(hclk), .com(com), .sel_cnt(sel_cnt));

    task automatic chk(input string nm, input logic [31:0] e, g);
        cmp_count++;
        if (g !== e) begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask
    // One single transfer; waits on hready, data taken at its edge
    task automatic ahb(input logic w, input logic [31:0] a, d);
        @(posedge hclk);
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= w;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask
    task automatic test_done;
        $display("mismatches %0d compares %0d", n_mismatch, cmp_count);
        if (n_mismatch == 0 && cmp_count > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    // Counts cycles where a common breaks the copy or fixed-level rule of a mode
    task automatic com_scan(input int m, output int bad);
        bad = 0;
        repeat (300) begin
            @(posedge hclk);
            #1;
            case (m)
                0: bad += (com[1] !== com[0] || com[2] !== com[0] ||
                           com[3] !== com[0]);
                1: bad += (com[3] !== com[2] || com[1] !== com[0]);
                2: bad += (com[3] !== LDC_NONSEL);
                3: bad += (com[3] !== LDC_GND);
                default: bad += (com[1] !== LDC_GND);
            endcase
        end
    endtask

    // Counts cycles out of 64 where common one is at the high select level
    task automatic hi_scan(output int n);
        n = 0;
        repeat (64) begin
            @(posedge hclk);
            #1;
            n += (com[0] === LDC_SEL_HI);
        end
    endtask

    initial begin
        #2_000_000;
        n_mismatch++;
        test_done();
    end

    initial begin
        repeat (4) @(posedge hclk);
        hresetn <= 1'b1;
        // Reset values and idle outputs
        chk("sup_rst", 0, sup);
        chk("reg_rst", 0, reg_on);
        ahb(0, 32'h300, 0);
        chk("duty_rst", 32'h00, rd);
        ahb(0, 32'h304, 0);
        chk("ctrl_rst", 32'h80, rd);
        ahb(0, 32'h308, 0);
        chk("drv_rst", 32'h60, rd);
        // Register rows: write, read back, compare levels
        foreach (row[i]) begin
            ahb(1, {20'h0, row[i][22:11]}, {24'h0, row[i][10:3]});
            ahb(0, {20'h0, row[i][22:11]}, 0);
            chk("row_rd", {24'h0, rdx[i]}, rd);
            chk("row_out", row[i][2:0], {sup, reg_on, show});
            chk("hresp", 0, hresp);
        end
        // Run with hclk/2 frame clock, then sweep charge pulse duty
        ahb(1, 32'h304, 32'h78);
        foreach (cds[i]) begin
            ahb(1, 32'h308, {28'h0, cds[i]});
            repeat (40) @(posedge hclk);
            k = 0;
            repeat (32) begin
                @(posedge hclk);
                #1;
                k += (chg === 1'b1);
            end
            chk("chg_hi", hi_x[i], k);
        end
        // Common copy and fixed-level modes, expansion on and off
        foreach (duty[i]) begin
            ahb(1, 32'h300, {24'h0, duty[i]});
            repeat (4) @(posedge hclk);
            com_scan(i, k);
            chk("com_mode", 0, k);
        end
        // Quarter duty drives common four
        ahb(1, 32'h300, 32'hC0);
        c0 = sel_cnt[3];
        repeat (300) @(posedge hclk);
        chk("common_out_four_act", 1, sel_cnt[3] != c0);
        // Wave A repeats common one's level per frame, B alternates it
        hi_scan(k);
        chk("wave_a", 1, k == 0 || k == 16);
        ahb(1, 32'h308, 32'h80);
        repeat (20) @(posedge hclk);
        hi_scan(k);
        chk("wave_b", 8, k);
        // Frame clock sources: static duty flips common one on each tick
        ahb(1, 32'h300, 32'h00);
        foreach (cks_v[i]) begin
            ahb(1, 32'h304, {28'h2, cks_v[i]});
            repeat (cks_w[i]) @(posedge hclk);
            #1;
            lv = com[0];
            k = 0;
            repeat (cks_w[i]) begin
                @(posedge hclk);
                #1;
                k += (com[0] !== lv);
                lv = com[0];
            end
            chk("frame_ticks", cks_n[i], k);
        end
        // Halt: status shows stopped, panel sees no selection
        ahb(1, 32'h304, 32'h58);
        ahb(0, 32'h30C, 0);
        chk("run_bit", 0, rd[3]);
        repeat (4) @(posedge hclk);
        c0 = sel_cnt[0];
        repeat (300) @(posedge hclk);
        chk("halt_sel", c0, sel_cnt[0]);
        // Reset while halted returns registers and levels to idle
        @(posedge hclk);
        hresetn <= 1'b0;
        repeat (2) @(posedge hclk);
        chk("sup_mid", 0, sup);
        chk("com_mid", LDC_GND, com[0]);
        hresetn <= 1'b1;
        ahb(0, 32'h304, 0);
        chk("ctrl_mid", 32'h80, rd);
        test_done();
    end
endmodule
